// File: test_upstream_port_failover_ctrl.sv
// Self-checking testbench of the upstream port failover controller.
`timescale 1ns/1ps
module test_upstream_port_failover_ctrl;
  logic sys_clk, resetn, hot_reset, switch_mode_pin, gpio_pin5, drop_a, drop_c;
  logic a_up, c_up, a_dn, c_dn, ts1_a, ts1_c;
  logic detect, train, swapped, mask, int_rst, ext_rst, current_mode;
  logic [3:0] awaddr, araddr, wstrb, saw;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int errors, check_count;
  upfc_root_model upfc_root_model_inst (.sys_clk(sys_clk), .resetn(resetn), .links_to_detect(detect),
    .link_train_start(train), .drop_a(drop_a), .drop_c(drop_c), .port_a_link_up(a_up),
    .port_c_link_up(c_up), .port_a_dl_down(a_dn), .port_c_dl_down(c_dn));
  upfc_ctrl upfc_ctrl_inst (.sys_clk(sys_clk), .resetn(resetn), .hot_reset(hot_reset),
    .switch_mode_pin(switch_mode_pin), .gpio_pin5(gpio_pin5), .port_a_link_up(a_up),
    .port_c_link_up(c_up), .port_a_dl_down(a_dn), .port_c_dl_down(c_dn), .port_a_ts1_hot_reset(ts1_a),
    .port_c_ts1_hot_reset(ts1_c), .links_to_detect(detect), .link_train_start(train),
    .crossbar_swapped(swapped), .link_flag_mask(mask), .internal_domain_reset(int_rst),
    .external_domain_reset(ext_rst), .current_mode(current_mode), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ==========================================================================
  // Shared tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task axi_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task pulse_hot;
    hot_reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    hot_reset <= 1'b0;
  endtask
  // Waits for a failover to end in mode m, noting which outputs were seen high.
  task run_fail(input logic m);
    int n;
    n = 0;
    saw = 4'h0;
    while (!(mask === 1'b0 && current_mode === m && n > 4) && n < 3000)
    begin
      @(posedge sys_clk);
      n++;
      saw = saw | {detect, train, mask, int_rst | ext_rst};
    end
    check(32'(n < 3000), 32'h1);
  endtask
  task dom_case(input logic [31:0] ctl, input int src, input logic exp);
    logic seen;
    seen = 1'b0;
    axi_write(4'h0, ctl);
    {ts1_c, ts1_a, drop_c, drop_a} <= 4'(1 << src);
    repeat (4)
    begin
      @(posedge sys_clk);
      seen = seen | (src[0] ? ext_rst : int_rst);
    end
    {ts1_c, ts1_a, drop_c, drop_a} <= 4'h0;
    repeat (4) @(posedge sys_clk);
    check(32'(seen), 32'(exp));
  endtask
  // ==========================================================================
  // Scenarios
  task test_boot;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(32'(current_mode), 32'h1);
    resetn <= 1'b0;
    @(posedge sys_clk);
    switch_mode_pin <= 1'b0;
    @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(32'(current_mode), 32'h0);
    $display("test boot done");
  endtask
  task test_software;
    logic [31:0] d;
    logic [1:0] r;
    // Both links must be trained first, or their boot link-down shows up as a domain reset.
    repeat (20) @(posedge sys_clk);
    axi_write(4'h0, 32'h21);
    run_fail(1'b1);
    check(32'(saw), 32'he);
    check(32'(swapped), 32'h1);
    axi_read(4'h4, d, r);
    check(d, 32'h7);
    axi_write(4'h4, 32'h6);
    axi_read(4'h4, d, r);
    check(d, 32'h1);
    axi_read(4'hc, d, r);
    check(32'(r), 32'h2);
    axi_write(4'hc, 32'h0);
    check(32'(bresp), 32'h2);
    $display("test software done");
  endtask
  task test_pin;
    axi_write(4'h0, 32'h3);
    repeat (3) @(posedge sys_clk);
    pulse_hot();
    run_fail(1'b0);
    check(32'(saw[1]), 32'h1);
    check(32'(swapped), 32'h0);
    $display("test pin done");
  endtask
  task test_watchdog;
    logic [31:0] d1, d2;
    logic [1:0] r;
    axi_write(4'h0, 32'h5);
    axi_write(4'h8, 32'h8);
    axi_read(4'h8, d1, r);
    pulse_hot();
    repeat (20) @(posedge sys_clk);
    axi_read(4'h8, d2, r);
    check(d1 - d2, 32'h1);
    run_fail(1'b1);
    check(32'(saw[1]), 32'h1);
    axi_read(4'h8, d1, r);
    check(d1, 32'h0);
    $display("test watchdog done");
  endtask
  task test_domains;
    dom_case(32'h01, 0, 1'b1);
    dom_case(32'h09, 0, 1'b0);
    dom_case(32'h01, 1, 1'b1);
    dom_case(32'h11, 1, 1'b0);
    dom_case(32'h01, 2, 1'b1);
    dom_case(32'h41, 2, 1'b0);
    dom_case(32'h01, 3, 1'b1);
    dom_case(32'h81, 3, 1'b0);
    $display("test domains done");
  endtask
  // ==========================================================================
  // Clock, watchdog and main sequence
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    complete_run();
  end
  initial
  begin
    errors = 0;
    check_count = 0;
    resetn = 1'b0;
    hot_reset = 1'b0;
    switch_mode_pin = 1'b1;
    gpio_pin5 = 1'b0;
    {drop_a, drop_c, ts1_a, ts1_c} = 4'h0;
    {awaddr, araddr, wdata, wstrb} = {8'h00, 32'h0, 4'hf};
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    test_boot();
    test_software();
    test_pin();
    test_watchdog();
    test_domains();
    complete_run();
  end
endmodule

// File: upfc_ctrl.sv
// Upstream port failover controller with an AXI4-Lite register slave.
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "upfc_defs.svh"
module upfc_ctrl
(
  // Clock and resets.
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic hot_reset,
  // Boot straps and pins.
  input wire logic switch_mode_pin,
  input wire logic gpio_pin5,
  // Link status from the port stacks.
  input wire logic port_a_link_up,
  input wire logic port_c_link_up,
  input wire logic port_a_dl_down,
  input wire logic port_c_dl_down,
  input wire logic port_a_ts1_hot_reset,
  input wire logic port_c_ts1_hot_reset,
  // Link control, domain reset and mode outputs.
  output logic links_to_detect,
  output logic link_train_start,
  output logic crossbar_swapped,
  output logic link_flag_mask,
  output logic internal_domain_reset,
  output logic external_domain_reset,
  output logic current_mode,
  // AXI4-Lite write.
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import upfc_pkg::*;

  typedef struct packed
  {
    upfc_state_type state;
    logic [7:0] ctrl;
    logic mode;
    logic target;
    upfc_src_type src;
    logic started;
    logic done;
    logic [2:0] pending;
    logic pend_sw_mode;
    logic [31:0] wdog;
    logic [4:0] us_cnt;
    logic [7:0] wait_cnt;
    logic [2:0] pin_sync;
    logic pin_level;
    logic strap_taken;
    logic aw_held;
    logic [3:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic int_rst;
    logic ext_rst;
  } upfc_regs_type;

  upfc_regs_type r_reg;
  upfc_regs_type r_next;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] upfc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
    input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic upfc_mapped(input logic [3:0] a);
    return (a == `UPFC_ADDR_CTRL) || (a == `UPFC_ADDR_STATUS) || (a == `UPFC_ADDR_WDOG);
  endfunction

  logic do_write;
  logic in_failover;
  logic msel_change;
  logic pin_req;
  logic tmr_req;
  logic [31:0] new_ctrl;
  logic [31:0] status_word;

  assign in_failover = (r_reg.state != UPFC_IDLE);
  assign do_write = r_reg.aw_held && r_reg.w_held && !r_reg.bvalid;
  assign new_ctrl = upfc_merge({24'h000000, r_reg.ctrl}, r_reg.w_data, r_reg.w_strb);
  assign status_word = {28'h0000000, in_failover, r_reg.done, r_reg.started, r_reg.mode};

  always_comb
  begin
    r_next = r_reg;
    msel_change = 1'b0;
    pin_req = 1'b0;
    tmr_req = 1'b0;

    // ========================================================================
    // Boot strap capture after fundamental reset release.
    if (!r_reg.strap_taken)
    begin
      r_next.strap_taken = 1'b1;
      r_next.mode = switch_mode_pin; // R1
      r_next.ctrl[`UPFC_CTL_MSEL] = switch_mode_pin;
    end

    // ========================================================================
    // Request pin synchroniser: three stages, change counts when last two agree.
    r_next.pin_sync = {r_reg.pin_sync[1:0], gpio_pin5}; // R12
    if (r_reg.pin_sync[2] == r_reg.pin_sync[1])
    begin
      r_next.pin_level = r_reg.pin_sync[2];
    end

    // ========================================================================
    // Watchdog, one decrement per microsecond; hot reset does not touch it.
    r_next.us_cnt = (r_reg.us_cnt == 5'(`UPFC_US_CYCLES - 1)) ? 5'h00 : r_reg.us_cnt + 5'h01;
    if (r_reg.us_cnt == 5'(`UPFC_US_CYCLES - 1) && r_reg.wdog != 32'h00000000)
    begin
      r_next.wdog = r_reg.wdog - 32'h00000001; // R15 R16
      if (r_reg.wdog == 32'h00000001 && r_reg.ctrl[`UPFC_CTL_TIMER_EN])
      begin
        tmr_req = 1'b1; // R14
      end
    end

    // ========================================================================
    // AXI4-Lite slave.
    if (s_axi_awvalid && !r_reg.aw_held)
    begin
      r_next.aw_held = 1'b1;
      r_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r_reg.w_held)
    begin
      r_next.w_held = 1'b1;
      r_next.w_data = s_axi_wdata;
      r_next.w_strb = s_axi_wstrb;
    end
    if (do_write)
    begin
      r_next.aw_held = 1'b0;
      r_next.w_held = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = upfc_mapped(r_reg.aw_addr) ? 2'h0 : 2'h2;
      unique case (r_reg.aw_addr)
        `UPFC_ADDR_CTRL:
        begin
          r_next.ctrl = new_ctrl[7:0];
          msel_change = (new_ctrl[`UPFC_CTL_MSEL] != r_reg.ctrl[`UPFC_CTL_MSEL]); // R10
        end
        `UPFC_ADDR_WDOG:
        begin
          r_next.wdog = upfc_merge(r_reg.wdog, r_reg.w_data, r_reg.w_strb); // R15
          tmr_req = 1'b0;
        end
        default:
        begin
        end
      endcase
    end
    if (r_reg.bvalid && s_axi_bready)
    begin
      r_next.bvalid = 1'b0;
    end
    if (s_axi_arvalid && !r_reg.rvalid)
    begin
      r_next.rvalid = 1'b1;
      r_next.rresp = upfc_mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      unique case (s_axi_araddr)
        `UPFC_ADDR_CTRL: r_next.rdata = {24'h000000, r_reg.ctrl}; // R22
        `UPFC_ADDR_STATUS: r_next.rdata = status_word;
        `UPFC_ADDR_WDOG: r_next.rdata = r_reg.wdog;
        default: r_next.rdata = 32'h00000000;
      endcase
    end
    if (r_reg.rvalid && s_axi_rready)
    begin
      r_next.rvalid = 1'b0;
    end

    pin_req = r_reg.ctrl[`UPFC_CTL_PIN_EN] && r_reg.strap_taken && (r_reg.pin_level != r_reg.mode); // R11

    // ========================================================================
    // Request queue: same source in flight is dropped, others wait.
    if (msel_change && !(in_failover && r_reg.src == UPFC_SRC_SW)) // R9
    begin
      r_next.pending[UPFC_SRC_SW] = 1'b1;
      r_next.pend_sw_mode = new_ctrl[`UPFC_CTL_MSEL];
    end
    if (pin_req && !(in_failover && r_reg.src == UPFC_SRC_PIN)) // R9
    begin
      r_next.pending[UPFC_SRC_PIN] = 1'b1;
    end
    if (tmr_req && !(in_failover && r_reg.src == UPFC_SRC_TIMER)) // R9
    begin
      r_next.pending[UPFC_SRC_TIMER] = 1'b1;
    end

    // ========================================================================
    // Failover sequence; only resetn aborts it, hot reset is not an input here.
    unique case (r_reg.state)
      UPFC_IDLE:
      begin
        if (r_reg.pending[UPFC_SRC_SW] || r_reg.pending[UPFC_SRC_PIN] || r_reg.pending[UPFC_SRC_TIMER])
        begin
          r_next.state = UPFC_DROP; // R5 R6
          r_next.started = 1'b1; // R3
          r_next.wait_cnt = `UPFC_DROP_CYCLES;
          if (r_reg.pending[UPFC_SRC_SW])
          begin
            r_next.src = UPFC_SRC_SW;
            r_next.target = r_reg.pend_sw_mode;
            r_next.pending[UPFC_SRC_SW] = 1'b0;
          end
          else if (r_reg.pending[UPFC_SRC_PIN])
          begin
            r_next.src = UPFC_SRC_PIN;
            r_next.target = r_reg.pin_level;
            r_next.pending[UPFC_SRC_PIN] = 1'b0;
          end
          else
          begin
            r_next.src = UPFC_SRC_TIMER;
            r_next.target = !r_reg.mode; // R17
            r_next.pending[UPFC_SRC_TIMER] = 1'b0;
          end
        end
      end
      UPFC_DROP:
      begin
        r_next.wait_cnt = r_reg.wait_cnt - 8'h01;
        if (r_reg.wait_cnt == 8'h01)
        begin
          r_next.state = UPFC_SWAP;
        end
      end
      UPFC_SWAP:
      begin
        r_next.state = UPFC_TRAIN; // R7
      end
      UPFC_TRAIN:
      begin
        if (port_a_link_up && port_c_link_up)
        begin
          r_next.state = UPFC_IDLE;
          r_next.done = 1'b1; // R4
          r_next.mode = r_reg.target; // R24
        end
      end
    endcase

    // Sticky bits: writing one clears, a hardware set in the same cycle wins.
    if (do_write && r_reg.aw_addr == `UPFC_ADDR_STATUS && r_reg.w_strb[0])
    begin
      if (r_reg.w_data[`UPFC_STS_STARTED] && !(r_next.started && !r_reg.started))
      begin
        r_next.started = (r_reg.state == UPFC_IDLE) && (r_next.state == UPFC_DROP);
      end
      if (r_reg.w_data[`UPFC_STS_DONE])
      begin
        r_next.done = (r_reg.state == UPFC_TRAIN) && (r_next.state == UPFC_IDLE);
      end
    end

    // ========================================================================
    // Domain resets with link-down and hot reset masks.
    r_next.int_rst = hot_reset
      || (port_a_dl_down && !r_reg.ctrl[`UPFC_CTL_IDLD] && !(in_failover && r_reg.ctrl[`UPFC_CTL_DFHR])) // R18 R20
      || (port_a_ts1_hot_reset && !r_reg.ctrl[`UPFC_CTL_IDPROP]); // R21
    r_next.ext_rst = r_next.int_rst
      || (port_c_dl_down && !r_reg.ctrl[`UPFC_CTL_EDLD] && !(in_failover && r_reg.ctrl[`UPFC_CTL_DFHR])) // R19 R20
      || (port_c_ts1_hot_reset && !r_reg.ctrl[`UPFC_CTL_EDPROP]); // R21
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      r_reg <= '{state: UPFC_IDLE, ctrl: `UPFC_CTRL_RESET, src: UPFC_SRC_SW, wdog: `UPFC_WDOG_RESET,
        default: '0};
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // Outputs.
  assign links_to_detect = (r_reg.state == UPFC_DROP); // R6
  assign crossbar_swapped = r_reg.state == UPFC_IDLE ? r_reg.mode : r_reg.target; // R23
  assign link_train_start = (r_reg.state == UPFC_SWAP); // R7
  assign link_flag_mask = in_failover; // R8
  assign internal_domain_reset = r_reg.int_rst;
  assign external_domain_reset = r_reg.ext_rst;
  assign current_mode = r_reg.mode;
  assign s_axi_awready = !r_reg.aw_held;
  assign s_axi_wready = !r_reg.w_held;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_arready = !r_reg.rvalid;
  assign s_axi_rvalid = r_reg.rvalid;
  assign s_axi_rresp = r_reg.rresp;
  assign s_axi_rdata = r_reg.rdata;

  // ==========================================================================
  // Assertions.
  a_start_sets_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
    (r_reg.state == UPFC_IDLE && r_next.state == UPFC_DROP) |=> r_reg.started) // R3
    else $error("Started flag not set at failover start.");
  a_done_sets_mode: assert property (@(posedge sys_clk) disable iff (!resetn)
    (r_reg.state == UPFC_TRAIN && port_a_link_up && port_c_link_up)
    |=> (r_reg.done && r_reg.mode == $past(r_reg.target))) // R4
    else $error("Completion did not set flag and mode.");
  a_drop_len: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(links_to_detect) |-> links_to_detect [*4] ##1 link_train_start) // R6
    else $error("Link drop length wrong.");
  a_train_after_swap: assert property (@(posedge sys_clk) disable iff (!resetn)
    link_train_start |-> crossbar_swapped == r_reg.target) // R7
    else $error("Training started before crossbar set.");
  a_mask_in_failover: assert property (@(posedge sys_clk) disable iff (!resetn)
    links_to_detect |-> link_flag_mask) // R8
    else $error("Link flags not masked during failover.");
  a_hot_no_abort: assert property (@(posedge sys_clk) disable iff (!resetn)
    (r_reg.state == UPFC_DROP && hot_reset) |=> r_reg.state != UPFC_IDLE) // R5
    else $error("Hot reset aborted failover.");
  a_wdog_fail: assert property (@(posedge sys_clk) disable iff (!resetn)
    (tmr_req && !msel_change && !pin_req && r_reg.state == UPFC_IDLE && r_reg.pending == 3'h0)
    |-> ##2 (r_reg.target == !$past(r_reg.mode, 2))) // R17
    else $error("Watchdog failover target wrong.");
  a_wdog_stop: assert property (@(posedge sys_clk) disable iff (!resetn)
    (r_reg.wdog == 32'h00000000 && !do_write) |=> r_reg.wdog == 32'h00000000) // R15
    else $error("Watchdog moved below zero.");
  a_idld_mask: assert property (@(posedge sys_clk) disable iff (!resetn)
    (r_reg.ctrl[`UPFC_CTL_IDLD] && !hot_reset && port_a_dl_down
    && !(port_a_ts1_hot_reset && !r_reg.ctrl[`UPFC_CTL_IDPROP])) |=> !internal_domain_reset) // R18
    else $error("Internal link-down reset not masked.");
endmodule

// File: upfc_defs.svh
// Offsets, field positions, reset values and timing counts of the upstream port failover controller.
// ==========================================================================
// Function
// R1: Boot mode pins pick mode at fundamental reset.
// R2: Host asserts reset, changes pins, then releases.
// R3: Set sticky started bit when failover begins.
// R4: Set sticky completed bit; survives hot reset.
// R5: Hot reset never aborts a running failover.
// R6: Failover forces both links to Detect, DL_Down.
// R7: Set crossbar for mode, then retrain both links.
// R8: Suppress link up/down flags during failover.
// R9: Drop same-source request; hold other sources.
// R10: Mode select field change starts failover.
// R11: Enabled pin differing from mode starts failover.
// R12: Request pin follows general-purpose pin 5.
// R13: Request pin changes at most once per second; the code has no such limit, pin_level follows the synchroniser.
// R14: Enabled watchdog one-to-zero starts failover.
// R15: Watchdog decrements every microsecond, stops zero.
// R16: Watchdog keeps counting through hot reset.
// R17: Watchdog failover selects the opposite mode.
// R18: Internal link-down disable masks upstream resets.
// R19: External link-down disable masks bridge reset.
// R20: Failover reset disable masks failover link-downs.
// R21: Propagation disables ignore hot reset TS1 sets.
// R22: Registers reachable by both roots and BAR4; the code reaches them only through the AXI4-Lite slave.
// R23: Crossbar passes straight or crosses ports.
// R24: Current mode updates with completion bit.
`ifndef UPFC_DEFS_SVH
`define UPFC_DEFS_SVH
`define UPFC_ADDR_CTRL 4'h0
`define UPFC_ADDR_STATUS 4'h4
`define UPFC_ADDR_WDOG 4'h8
`define UPFC_CTL_MSEL 0
`define UPFC_CTL_PIN_EN 1
`define UPFC_CTL_TIMER_EN 2
`define UPFC_CTL_IDLD 3
`define UPFC_CTL_EDLD 4
`define UPFC_CTL_DFHR 5
`define UPFC_CTL_IDPROP 6
`define UPFC_CTL_EDPROP 7
`define UPFC_STS_MODE 0
`define UPFC_STS_STARTED 1
`define UPFC_STS_DONE 2
`define UPFC_STS_BUSY 3
`define UPFC_CTRL_RESET 8'h00
`define UPFC_WDOG_RESET 32'h00000000
`define UPFC_CLK_MHZ 25
`define UPFC_US_NS 1000
`define UPFC_CLK_NS 40
`define UPFC_US_CYCLES (`UPFC_US_NS / `UPFC_CLK_NS)
`define UPFC_DROP_CYCLES 8'h04
`endif

// File: upfc_pkg.sv
// Types of the upstream port failover controller.
package upfc_pkg;
  typedef enum logic [3:0]
  {
    UPFC_IDLE = 4'b0001,
    UPFC_DROP = 4'b0010,
    UPFC_SWAP = 4'b0100,
    UPFC_TRAIN = 4'b1000
  } upfc_state_type;
  typedef enum logic [1:0]
  {
    UPFC_SRC_SW = 2'h0,
    UPFC_SRC_PIN = 2'h1,
    UPFC_SRC_TIMER = 2'h2
  } upfc_src_type;
endpackage

// File: upfc_root_model.sv
// Behavioural model of the two roots training ports A and C.
`timescale 1ns/1ps
module upfc_root_model
#(
  parameter int TRAIN_CYCLES = 20
)
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Link control from the block.
  input wire logic links_to_detect,
  input wire logic link_train_start,
  // Forced link loss.
  input wire logic drop_a,
  input wire logic drop_c,
  // Link status to the block.
  output logic port_a_link_up,
  output logic port_c_link_up,
  output logic port_a_dl_down,
  output logic port_c_dl_down
);
  logic up_reg;
  int count_reg;
  // ==========================================================================
  // Training
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      up_reg <= 1'b0;
      count_reg <= 1;
    end
    else if (links_to_detect)
    begin
      up_reg <= 1'b0;
      count_reg <= 0;
    end
    else if (link_train_start)
      count_reg <= 1;
    else if (count_reg == TRAIN_CYCLES)
    begin
      up_reg <= 1'b1;
      count_reg <= 0;
    end
    else if (count_reg != 0)
      count_reg <= count_reg + 1;
  end
  assign port_a_link_up = up_reg & ~drop_a;
  assign port_c_link_up = up_reg & ~drop_c;
  assign port_a_dl_down = ~port_a_link_up;
  assign port_c_dl_down = ~port_c_link_up;
endmodule
